/* rtl/mam_pkg.sv */
// Shared constants for the multiply-accumulate block and its register slave.
package mam_pkg;

    // Operand and result widths.
    localparam int MAM_A_W_NARROW = 18;
    localparam int MAM_A_W_WIDE   = 36;
    localparam int MAM_B_W        = 27;
    localparam int MAM_C_W        = 48;
    localparam int MAM_RES_W      = 64;

    // Register bus geometry.
    localparam int MAM_WB_ADR_W = 8;
    localparam int MAM_WB_DAT_W = 32;

    // Register byte offsets.
    localparam logic [MAM_WB_ADR_W-1:0] MAM_OFS_CTRL   = 8'h00;
    localparam logic [MAM_WB_ADR_W-1:0] MAM_OFS_RES_LO = 8'h04;
    localparam logic [MAM_WB_ADR_W-1:0] MAM_OFS_RES_HI = 8'h08;
    localparam logic [MAM_WB_ADR_W-1:0] MAM_OFS_CFG    = 8'h0C;

    // Control register fields and reset value.
    localparam int                      MAM_CTRL_CLR_BIT  = 0;
    localparam int                      MAM_CTRL_HOLD_BIT = 1;
    localparam logic                    MAM_CTRL_HOLD_RST = 1'h0;

    // Configuration register field positions.
    localparam int MAM_CFG_WIDE_BIT   = 0;
    localparam int MAM_CFG_INREG_BIT  = 1;
    localparam int MAM_CFG_PPIPE_BIT  = 2;
    localparam int MAM_CFG_ADDEND_BIT = 3;
    localparam int MAM_CFG_ACC_BIT    = 4;
    localparam int MAM_CFG_W          = 5;

    // Reset and clear value of the result.
    localparam logic [MAM_RES_W-1:0] MAM_RES_RST = 64'h0000_0000_0000_0000;

endpackage : mam_pkg

/* rtl/mam_wb_regs.sv */
// Classic Wishbone register slave for the multiply-accumulate block.
`timescale 1ns/1ps
`default_nettype none
module mam_wb_regs
    import mam_pkg::*;
(
    input  wire logic                    clk_sys,    // System clock.
    input  wire logic                    resetn,     // Asynchronous reset, active low.
    input  wire logic                    wb_cyc_i,   // Bus cycle.
    input  wire logic                    wb_stb_i,   // Strobe.
    input  wire logic                    wb_we_i,    // Write enable.
    input  wire logic [MAM_WB_ADR_W-1:0] wb_adr_i,   // Byte address.
    input  wire logic [3:0]              wb_sel_i,   // Byte selects.
    input  wire logic [MAM_WB_DAT_W-1:0] wb_dat_i,   // Write data.
    output logic      [MAM_WB_DAT_W-1:0] wb_dat_o,   // Read data.
    output logic                         wb_ack_o,   // Acknowledge.
    input  wire logic [MAM_RES_W-1:0]    result,     // Current result.
    input  wire logic [MAM_CFG_W-1:0]    cfg_bits,   // Build options.
    output logic                         acc_clear,  // One-cycle clear of the result.
    output logic                         acc_hold    // Freeze the result.
);

    typedef struct packed {
        logic                    ack;
        logic [MAM_WB_DAT_W-1:0] dat;
        logic [MAM_WB_DAT_W-1:0] hi_snap;
        logic                    clr;
        logic                    hold;
    } mam_wb_s;

    mam_wb_s st_r;
    mam_wb_s st_nxt;
    logic    req;

    assign req       = wb_cyc_i & wb_stb_i & ~st_r.ack;
    assign wb_ack_o  = st_r.ack;
    assign wb_dat_o  = st_r.dat;
    assign acc_clear = st_r.clr;
    assign acc_hold  = st_r.hold;

    always_comb begin
        st_nxt     = st_r;
        st_nxt.ack = req;
        st_nxt.clr = 1'b0;
        if (req && wb_we_i) begin
            if (wb_adr_i == MAM_OFS_CTRL && wb_sel_i[0]) begin
                st_nxt.clr  = wb_dat_i[MAM_CTRL_CLR_BIT];
                st_nxt.hold = wb_dat_i[MAM_CTRL_HOLD_BIT];
            end
        end else if (req) begin
            // Reading the low word snapshots the high word so a 64-bit read never tears.
            unique case (wb_adr_i)
                MAM_OFS_CTRL: begin
                    st_nxt.dat                    = '0;
                    st_nxt.dat[MAM_CTRL_HOLD_BIT] = st_r.hold;
                end
                MAM_OFS_RES_LO: begin
                    st_nxt.dat     = result[MAM_WB_DAT_W-1:0];
                    st_nxt.hi_snap = result[MAM_RES_W-1:MAM_WB_DAT_W];
                end
                MAM_OFS_RES_HI: st_nxt.dat = st_r.hi_snap;
                MAM_OFS_CFG:    st_nxt.dat = {{(MAM_WB_DAT_W-MAM_CFG_W){1'b0}}, cfg_bits};
                default:        st_nxt.dat = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_r <= '{ack: 1'b0, dat: '0, hi_snap: '0, clr: 1'b0, hold: MAM_CTRL_HOLD_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : mam_wb_regs
`default_nettype wire

/* rtl/mam_top.sv */
// Signed multiply-accumulate datapath with optional pipeline stages and register slave.
// Notes on behaviour
// - Multiplicand is 18 or 36 bits, default 18.
// - Multiplicand is signed and multiplied by B.
// - Second operand is signed 27 bits.
// - Input stage adds exactly one cycle.
// - Product stage adds one more cycle.
// - Optional signed 48-bit addend joins the product.
// - Accumulate adds product plus addend each cycle.
// - Result is signed 64 bits wide.
// - Reset low forces the result to zero.
// - Every option combination up to 36x27+48 into 64.
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module mam_top
    import mam_pkg::*;
#(
    parameter int unsigned A_WIDTH             = MAM_A_W_NARROW,  // 18 or 36.
    parameter bit          INPUT_REG_EN        = 1'b0,            // Register A, B and C.
    parameter bit          PRODUCT_PIPE_ENABLE = 1'b0,            // Register the product.
    parameter bit          ADDEND_ENABLE       = 1'b0,            // Use the addend port.
    parameter bit          ACC_ENABLE          = 1'b0             // Accumulate into the result.
)
(
    input  wire logic                    clk_sys,   // System clock, 250 MHz.
    input  wire logic                    resetn,    // Asynchronous reset, active low.
    input  wire logic [A_WIDTH-1:0]      a_in,      // Signed multiplicand.
    input  wire logic [MAM_B_W-1:0]      b_in,      // Signed multiplier.
    input  wire logic [MAM_C_W-1:0]      c_in,      // Signed addend.
    output logic      [MAM_RES_W-1:0]    dout,      // Signed result.
    input  wire logic                    wb_cyc_i,  // Wishbone cycle.
    input  wire logic                    wb_stb_i,  // Wishbone strobe.
    input  wire logic                    wb_we_i,   // Wishbone write enable.
    input  wire logic [MAM_WB_ADR_W-1:0] wb_adr_i,  // Wishbone byte address.
    input  wire logic [3:0]              wb_sel_i,  // Wishbone byte selects.
    input  wire logic [MAM_WB_DAT_W-1:0] wb_dat_i,  // Wishbone write data.
    output logic      [MAM_WB_DAT_W-1:0] wb_dat_o,  // Wishbone read data.
    output logic                         wb_ack_o   // Wishbone acknowledge.
);

    // Cycles from an operand at the ports to its effect on dout.
    localparam int LAT = 1 + int'(INPUT_REG_EN) + int'(PRODUCT_PIPE_ENABLE);

    typedef struct packed {
        logic signed [A_WIDTH-1:0]   a;
        logic signed [MAM_B_W-1:0]   b;
        logic signed [MAM_C_W-1:0]   c;
        logic signed [MAM_RES_W-1:0] prod;
        logic signed [MAM_C_W-1:0]   c_p;
        logic signed [MAM_RES_W-1:0] res;
        logic [1:0]                  warm;
    } mam_core_s;

    mam_core_s st_r;
    mam_core_s st_nxt;

    logic signed [A_WIDTH-1:0]   a_eff;
    logic signed [MAM_B_W-1:0]   b_eff;
    logic signed [MAM_C_W-1:0]   c_eff;
    logic signed [MAM_RES_W-1:0] mult;
    logic signed [MAM_RES_W-1:0] p_eff;
    logic signed [MAM_C_W-1:0]   c_add;
    logic signed [MAM_RES_W-1:0] term;
    logic                        acc_clear;
    logic                        acc_hold;
    logic [MAM_CFG_W-1:0]        cfg_bits;

    always_comb begin
        cfg_bits                     = '0;
        cfg_bits[MAM_CFG_WIDE_BIT]   = (A_WIDTH == MAM_A_W_WIDE);
        cfg_bits[MAM_CFG_INREG_BIT]  = INPUT_REG_EN;
        cfg_bits[MAM_CFG_PPIPE_BIT]  = PRODUCT_PIPE_ENABLE;
        cfg_bits[MAM_CFG_ADDEND_BIT] = ADDEND_ENABLE;
        cfg_bits[MAM_CFG_ACC_BIT]    = ACC_ENABLE;
    end

    mam_wb_regs u_regs (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_we_i   (wb_we_i),
        .wb_adr_i  (wb_adr_i),
        .wb_sel_i  (wb_sel_i),
        .wb_dat_i  (wb_dat_i),
        .wb_dat_o  (wb_dat_o),
        .wb_ack_o  (wb_ack_o),
        .result    (st_r.res),
        .cfg_bits  (cfg_bits),
        .acc_clear (acc_clear),
        .acc_hold  (acc_hold)
    );

    always_comb begin
        st_nxt = st_r;

        // Input stage: bypassed when the option is off.
        st_nxt.a = a_in;
        st_nxt.b = b_in;
        st_nxt.c = ADDEND_ENABLE ? c_in : '0;
        a_eff    = INPUT_REG_EN ? st_r.a : a_in;
        b_eff    = INPUT_REG_EN ? st_r.b : b_in;
        if (!ADDEND_ENABLE) begin
            c_eff = '0;
        end else begin
            c_eff = INPUT_REG_EN ? st_r.c : c_in;
        end

        // Full signed product; 36x27 fits in 63 bits, so 64 never overflows.
        mult       = MAM_RES_W'(a_eff) * MAM_RES_W'(b_eff);
        st_nxt.prod = mult;
        st_nxt.c_p  = c_eff;
        p_eff      = PRODUCT_PIPE_ENABLE ? st_r.prod : mult;
        c_add      = PRODUCT_PIPE_ENABLE ? st_r.c_p : c_eff;
        term       = p_eff + MAM_RES_W'(c_add);

        // Clear wins over hold; the sum wraps modulo 2^64.
        if (acc_clear) begin
            st_nxt.res = MAM_RES_RST;
        end else if (acc_hold) begin
            st_nxt.res = st_r.res;
        end else if (ACC_ENABLE) begin
            st_nxt.res = st_r.res + term;
        end else begin
            st_nxt.res = term;
        end

        // Cycles of undisturbed flow since reset, clear or hold, for the checks below.
        if (acc_clear || acc_hold) begin
            st_nxt.warm = '0;
        end else if (int'(st_r.warm) < LAT) begin
            st_nxt.warm = st_r.warm + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_r <= '{a: '0, b: '0, c: '0, prod: '0, c_p: '0, res: MAM_RES_RST, warm: 2'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.res;

    // Reference term built from the current port values; the checks take it LAT cycles later.
    logic signed [MAM_RES_W-1:0] ref_term;
    always_comb begin
        ref_term = MAM_RES_W'($signed(a_in)) * MAM_RES_W'($signed(b_in));
        if (ADDEND_ENABLE) begin
            ref_term = ref_term + MAM_RES_W'($signed(c_in));
        end
    end

    default clocking mam_cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    AST_A_WIDTH_LEGAL: assert property (A_WIDTH == MAM_A_W_NARROW || A_WIDTH == MAM_A_W_WIDE)
        else $error("Multiplicand width is neither 18 nor 36.");

    AST_RESET_ZERO: assert property (@(posedge clk_sys) disable iff (1'b0) !resetn |-> dout == '0)
        else $error("Result is not zero while reset is low.");

    AST_CLEAR_ZERO: assert property (acc_clear |=> dout == '0)
        else $error("Result is not zero after a clear.");

    AST_HOLD_STABLE: assert property (acc_hold && !acc_clear |=> $stable(dout))
        else $error("Result moved while held.");

    if (INPUT_REG_EN) begin : g_in_chk
        AST_INPUT_STAGE: assert property (st_r.a == $past(a_in) && st_r.b == $past(b_in))
            else $error("Input stage does not hold last cycle's operands.");
    end

    if (PRODUCT_PIPE_ENABLE) begin : g_prod_chk
        AST_PRODUCT_STAGE: assert property (st_r.prod == $past(mult))
            else $error("Product stage does not hold last cycle's product.");
    end

    if (!ADDEND_ENABLE) begin : g_noadd_chk
        AST_NO_ADDEND: assert property (c_eff == '0 && st_r.c_p == '0)
            else $error("Disabled addend is not zero.");
    end

    if (!ACC_ENABLE) begin : g_plain_chk
        AST_LATENCY_VALUE: assert property (int'(st_r.warm) == LAT |-> dout == $past(ref_term, LAT))
            else $error("Result is not A*B+C from the expected cycle.");
        AST_SIGN_EXT: assert property (int'(st_r.warm) == LAT && !ADDEND_ENABLE
                                       |-> dout[MAM_RES_W-1] == dout[A_WIDTH+MAM_B_W-2])
            else $error("Result is not sign extended to 64 bits.");
    end else begin : g_acc_chk
        AST_ACC_STEP: assert property (int'(st_r.warm) == LAT && !acc_clear && !acc_hold
                                       |=> dout == $past(dout) + $past(ref_term, LAT))
            else $error("Accumulator did not add the expected term.");
    end

endmodule : mam_top
`default_nettype wire

/* tb/mam_fabric.sv */
// Operand source that stands in for the fabric logic in front of the datapath.
`timescale 1ns/1ps
`default_nettype none
module mam_fabric
    import mam_pkg::*;
#(
    parameter int unsigned A_WIDTH = MAM_A_W_WIDE  // Multiplicand width.
)
(
    input  wire logic               clk_sys,  // System clock.
    input  wire logic               resetn,   // Reset, active low.
    input  wire logic               ld,       // Present the next operands.
    input  wire logic [A_WIDTH-1:0] nxt_a,    // Next multiplicand.
    input  wire logic [MAM_B_W-1:0] nxt_b,    // Next multiplier.
    input  wire logic [MAM_C_W-1:0] nxt_c,    // Next addend.
    output logic      [A_WIDTH-1:0] a_in,     // Multiplicand to the datapath.
    output logic      [MAM_B_W-1:0] b_in,     // Multiplier to the datapath.
    output logic      [MAM_C_W-1:0] c_in      // Addend to the datapath.
);
    // A slow fabric repeats its last operands while ld is low.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            a_in <= '0;
            b_in <= '0;
            c_in <= '0;
        end else if (ld) begin
            a_in <= nxt_a;
            b_in <= nxt_b;
            c_in <= nxt_c;
        end
    end
endmodule : mam_fabric
`default_nettype wire

/* tb/mam_top_bench.sv */
// Self-checking bench of the multiply-accumulate block in its largest configuration.
`timescale 1ns/1ps
`default_nettype none
module mam_top_bench
    import mam_pkg::*;
;
    localparam int unsigned AW  = MAM_A_W_WIDE;
    localparam bit          IR  = 1'b1;
    localparam bit          PP  = 1'b1;
    localparam bit          AD  = 1'b1;
    localparam bit          AC  = 1'b1;
    localparam int          LAT = 1 + IR + PP;
    logic                    clk_sys, resetn, ld, cyc, stb, we, wb_ack_o, chk_en;
    logic [AW-1:0]           na, a_in;
    logic [MAM_B_W-1:0]      nb, b_in;
    logic [MAM_C_W-1:0]      nc, c_in;
    logic [MAM_RES_W-1:0]    dout, held;
    logic [7:0]              adr;
    logic [31:0]             dat, rd, wb_dat_o;
    int                      n_mismatch, tests_run, cycles;
    longint                  exp_v;
    longint                  pipe[$];

    mam_fabric #(.A_WIDTH(AW)) i_fab (.clk_sys(clk_sys), .resetn(resetn), .ld(ld), .nxt_a(na), .nxt_b(nb),
        .nxt_c(nc), .a_in(a_in), .b_in(b_in), .c_in(c_in));
    mam_top #(.A_WIDTH(AW), .INPUT_REG_EN(IR), .PRODUCT_PIPE_ENABLE(PP), .ADDEND_ENABLE(AD), .ACC_ENABLE(AC)) i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .a_in(a_in), .b_in(b_in), .c_in(c_in), .dout(dout),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] expv);
        tests_run++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, expv);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // Reference model: signed product plus addend, delayed by the pipeline, then accumulated.
    always @(posedge clk_sys) begin
        longint t;
        t = longint'($signed(a_in)) * longint'($signed(b_in)) + (AD ? longint'($signed(c_in)) : 64'sh0);
        if (!resetn) begin
            pipe = {};
            repeat (LAT - 1) pipe.push_back(0);
            exp_v = 0;
        end else begin
            pipe.push_back(t);
            t = pipe.pop_front();
            exp_v = AC ? exp_v + t : t;
        end
        #1;
        if (chk_en) chk(dout, resetn ? exp_v : 64'h0);
    end

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        n = 0;
        // Ack and read data are looked at and taken mid-cycle, where they have settled; the cycle ends at the next rising edge.
        do begin
            @(negedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            report_and_stop();
        end
        r = wb_dat_o;
        @(posedge clk_sys);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    // Random operands with a most-negative corner every eighth cycle and random fabric stalls.
    task automatic run(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            ld <= ($urandom_range(0, 3) != 0);
            na <= (i % 8 == 0) ? {1'b1, {(AW-1){1'b0}}} : AW'({$urandom(), $urandom()});
            nb <= (i % 8 == 0) ? {1'b1, 26'h0} : MAM_B_W'($urandom());
            nc <= (i % 8 == 0) ? {1'b1, 47'h0} : MAM_C_W'({$urandom(), $urandom()});
        end
        @(posedge clk_sys);
        ld <= 1'b1;
        na <= '0;
        nb <= '0;
        nc <= '0;
        repeat (LAT + 3) @(posedge clk_sys);
    endtask : run

    initial begin
        void'($urandom(43));
        {resetn, ld, cyc, stb, we, adr, dat, na, nb, nc} = '0;
        {n_mismatch, tests_run, cycles} = '0;
        chk_en = 1'b1;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        wb(1'b0, MAM_OFS_CFG, 32'h0, rd);
        chk({32'h0, rd}, 64'h1F);
        wb(1'b0, 8'h10, 32'h0, rd);
        chk({32'h0, rd}, 64'h0);
        run(200);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        run(200);
        wb(1'b0, MAM_OFS_RES_LO, 32'h0, rd);
        chk({32'h0, rd}, {32'h0, exp_v[31:0]});
        wb(1'b0, MAM_OFS_RES_HI, 32'h0, rd);
        chk({32'h0, rd}, {32'h0, exp_v[63:32]});
        chk_en = 1'b0;
        // Hold freezes the result while the operands keep changing.
        wb(1'b1, MAM_OFS_CTRL, 32'h2, rd);
        wb(1'b0, MAM_OFS_CTRL, 32'h0, rd);
        chk({32'h0, rd}, 64'h2);
        @(negedge clk_sys);
        held = dout;
        run(20);
        chk(dout, held);
        wb(1'b1, MAM_OFS_CTRL, 32'h1, rd);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        exp_v  = 0;
        chk_en = 1'b1;
        wb(1'b0, MAM_OFS_CTRL, 32'h0, rd);
        chk({32'h0, rd}, 64'h0);
        run(50);
        report_and_stop();
    end
endmodule : mam_top_bench
`default_nettype wire
